// file: src/ckc_clock_ctrl.sv
// Clock generation controller: registers, PLL dividers, clock selectors.
// Assumes the oscillator input is already synchronous to ref_clk and the
// analog PLL reports its raw lock on pll_lock_raw.
`timescale 1ns/1ps
module ckc_clock_ctrl
	import ckc_pkg::*;
#(
	parameter int LOCK_FILTER = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Oscillator, power modes and analog PLL
	input wire logic osc_in,
	input wire logic power_down,
	input wire logic idle,
	input wire logic pll_lock_raw,
	output logic [1:0] osc_range_sel,
	output logic osc_amp_enable,
	output logic pll_run,
	output logic pll_ref_clk,
	output logic pll_feedback_clk,
	output logic pll_locked_flag,
	// Generated clocks
	output logic osc_clk,
	output logic cpu_clk,
	output logic per_clk,
	output logic dataflow_flash_clk,
	output logic card_clk,
	output logic serial_baud_clk
);
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] en;
		logic [7:0] sel;
		logic [7:0] pll;
		logic [7:0] card;
		logic [7:0] rdata;
		logic lock_s1, lock_s2;
		logic [7:0] lock_cnt;
		logic locked;
		logic [CKC_NCO_N-1:0][CKC_NCO_W-1:0] acc;
		logic osc_q, osc_out, osc_half, amp_en;
		logic [1:0] range;
		logic pll_run;
		logic [4:0] ref_cnt;
		logic ref_out, f12_q;
		logic [4:0] fb_cnt;
		logic fb_out;
		logic [1:0] sys_sel;
		logic sys_q, sys_half, cpu_out, per_out;
		logic [2:0] dnf_sel;
		logic dnf_out;
		logic [2:0] card_sel;
		logic card_q;
		logic [4:0] card_cnt;
		logic card_out, ser_sel, ser_out;
	} ckc_state_s;

	ckc_state_s s;
	ckc_state_s next_s;

	// ==========================================================
	// Divider helpers: count source rises, high for first half
	function automatic logic [4:0] ckc_div_step(input logic [4:0] cnt,
		input logic [4:0] m, input logic rise);
		if (!rise)
			return cnt;
		return (cnt + 5'h01 >= m) ? 5'h00 : cnt + 5'h01;
	endfunction : ckc_div_step

	function automatic logic ckc_div_out(input logic src,
		input logic [4:0] cnt, input logic [4:0] m);
		if (m == 5'h00)
			return 1'b0;
		if (m == 5'h01)
			return src;
		return cnt < {1'b0, m[4:1]};
	endfunction : ckc_div_out

	// ==========================================================
	// Next state
	logic gen_on;
	logic [CKC_NCO_N-1:0] nco;
	logic [3:0] sys_src;
	logic [7:0] dnf_src;
	logic [7:0] card_src;
	logic [1:0] ser_src;
	logic [1:0] fb_src;
	logic [4:0] n_div, r_div, card_div;
	logic sys_v, card_v;
	logic [1:0] want_sys;
	logic [2:0] want_dnf, want_card;

	always_comb begin
		next_s = s;
		gen_on = s.en[CKC_EN_GEN] && s.en[CKC_EN_PLL];
		for (int i = 0; i < CKC_NCO_N; i++) begin
			nco[i] = s.acc[i][CKC_NCO_W-1];
			// Accumulators parked at zero keep every output low
			next_s.acc[i] = gen_on ? s.acc[i] + ckc_nco_inc(CKC_NCO_KHZ[i])
				: '0;
		end
		n_div = {1'b0, s.pll[CKC_PLL_N_LSB +: 4]} + 5'h01;
		r_div = {1'b0, s.pll[CKC_PLL_R_LSB +: 4]} + 5'h01;
		card_div = s.card[CKC_CARD_DIV_LSB +: 5];
		want_sys = s.sel[CKC_SEL_SYS_LSB +: 2];
		want_dnf = s.sel[CKC_SEL_DNF_LSB +: 3];
		want_card = s.card[CKC_CARD_SEL_LSB +: 3];

		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				CKC_OFS_CONFIG: next_s.cfg = reg_wdata & CKC_CONFIG_WMASK;
				CKC_OFS_ENABLE: next_s.en = reg_wdata & CKC_ENABLE_WMASK;
				CKC_OFS_SELECT: next_s.sel = reg_wdata;
				CKC_OFS_PLLDIV: next_s.pll = reg_wdata;
				CKC_OFS_CARD: next_s.card = reg_wdata;
				default: ;
			endcase
		end
		// Read data stands for exactly one cycle; unmapped reads zero
		next_s.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				CKC_OFS_CONFIG: next_s.rdata = s.cfg;
				CKC_OFS_ENABLE: next_s.rdata = s.en
					| (8'(s.locked) << CKC_EN_LOCK);
				CKC_OFS_SELECT: next_s.rdata = s.sel;
				CKC_OFS_PLLDIV: next_s.rdata = s.pll;
				CKC_OFS_CARD: next_s.rdata = s.card;
				default: next_s.rdata = 8'h00;
			endcase
		end

		// Oscillator, amplifier and power-down
		next_s.range = s.cfg[CKC_CFG_RANGE_LSB +: 2];
		next_s.amp_en = !s.cfg[CKC_CFG_AMP_OFF] && !power_down;
		next_s.osc_out = osc_in && !power_down;
		next_s.osc_q = osc_in;
		if (osc_in && !s.osc_q)
			next_s.osc_half = !s.osc_half;

		// Lock filter: raw lock must hold LOCK_FILTER cycles
		next_s.lock_s1 = pll_lock_raw;
		next_s.lock_s2 = s.lock_s1;
		next_s.pll_run = s.en[CKC_EN_PLL];
		if (!s.en[CKC_EN_PLL] || !s.lock_s2) begin
			next_s.lock_cnt = 8'h00;
			next_s.locked = 1'b0;
		end else if (s.lock_cnt == 8'(LOCK_FILTER - 1)) begin
			next_s.locked = 1'b1;
		end else begin
			next_s.lock_cnt = s.lock_cnt + 8'h01;
		end

		// PLL reference and feedback dividers
		next_s.ref_cnt = ckc_div_step(s.ref_cnt, n_div,
			osc_in && !s.osc_q);
		next_s.ref_out = s.en[CKC_EN_PLL]
			&& ckc_div_out(osc_in, s.ref_cnt, n_div);
		next_s.f12_q = nco[CKC_F12];
		next_s.fb_cnt = ckc_div_step(s.fb_cnt, r_div,
			nco[CKC_F12] && !s.f12_q);
		fb_src = s.sel[CKC_SEL_FB_LSB +: 2];
		unique case (fb_src)
			2'h0: next_s.fb_out = nco[CKC_F12];
			2'h1: next_s.fb_out = nco[CKC_F16];
			2'h2: next_s.fb_out = nco[CKC_F20];
			default: next_s.fb_out = ckc_div_out(nco[CKC_F12], s.fb_cnt,
				r_div);
		endcase

		// Sources of each selector
		sys_src = {nco[CKC_F40], nco[CKC_F30], nco[CKC_F24], s.osc_out};
		dnf_src = {nco[CKC_F16], nco[CKC_F20], nco[CKC_F24], nco[CKC_F30],
			nco[CKC_F40], nco[CKC_F48], nco[CKC_F60], s.osc_out};
		card_src = {s.osc_half && !power_down, nco[CKC_F16], nco[CKC_F20],
			nco[CKC_F24], nco[CKC_F30], nco[CKC_F48], nco[CKC_F60],
			s.osc_out};
		ser_src = {nco[CKC_F120], s.osc_out};

		// Selects staged; switch only while old and new both low
		if (s.sys_sel != want_sys && !sys_src[s.sys_sel]
			&& !sys_src[want_sys])
			next_s.sys_sel = want_sys;
		if (s.dnf_sel != want_dnf && !dnf_src[s.dnf_sel]
			&& !dnf_src[want_dnf])
			next_s.dnf_sel = want_dnf;
		if (s.card_sel != want_card && !card_src[s.card_sel]
			&& !card_src[want_card])
			next_s.card_sel = want_card;
		if (s.ser_sel != s.sel[CKC_SEL_SER] && !ser_src[s.ser_sel]
			&& !ser_src[s.sel[CKC_SEL_SER]])
			next_s.ser_sel = s.sel[CKC_SEL_SER];

		// System clock: standard mode halves, double speed passes
		sys_v = sys_src[s.sys_sel];
		next_s.sys_q = sys_v;
		if (sys_v && !s.sys_q)
			next_s.sys_half = !s.sys_half;
		next_s.per_out = s.cfg[CKC_CFG_X2] ? sys_v : s.sys_half;
		next_s.cpu_out = next_s.per_out && !idle && !power_down;

		next_s.dnf_out = s.en[CKC_EN_DNF] && dnf_src[s.dnf_sel];
		next_s.ser_out = s.en[CKC_EN_SERIAL] && ser_src[s.ser_sel];

		// Card clock: divider of zero gives no clock
		card_v = card_src[s.card_sel];
		next_s.card_q = card_v;
		next_s.card_cnt = ckc_div_step(s.card_cnt, card_div,
			card_v && !s.card_q);
		next_s.card_out = s.en[CKC_EN_CARD]
			&& ckc_div_out(card_v, s.card_cnt, card_div);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			s <= '0;
		else
			s <= next_s;
	end

	assign reg_rdata = s.rdata;
	assign osc_range_sel = s.range;
	assign osc_amp_enable = s.amp_en;
	assign pll_run = s.pll_run;
	assign pll_ref_clk = s.ref_out;
	assign pll_feedback_clk = s.fb_out;
	assign pll_locked_flag = s.locked;
	assign osc_clk = s.osc_out;
	assign cpu_clk = s.cpu_out;
	assign per_clk = s.per_out;
	assign dataflow_flash_clk = s.dnf_out;
	assign card_clk = s.card_out;
	assign serial_baud_clk = s.ser_out;

	// ==========================================================
	// Assertions
	property p_lock_drop;
		@(posedge ref_clk) disable iff (!nrst)
		!s.en[CKC_EN_PLL] |=> !pll_locked_flag;
	endproperty
	a_lock_drop: assert property (p_lock_drop)
		else $error("lock flag set with PLL disabled");

	property p_lock_filter;
		@(posedge ref_clk) disable iff (!nrst)
		$rose(pll_locked_flag) |-> $past(s.en[CKC_EN_PLL])
			&& $past(s.lock_s2) && $past(s.lock_s2, LOCK_FILTER);
	endproperty
	a_lock_filter: assert property (p_lock_filter)
		else $error("lock flag rose without stable raw lock");

	property p_gen_off;
		@(posedge ref_clk) disable iff (!nrst)
		!s.en[CKC_EN_GEN] ##1 !s.en[CKC_EN_GEN] |-> s.acc == '0;
	endproperty
	a_gen_off: assert property (p_gen_off)
		else $error("generator running while disabled");

	property p_card_zero;
		@(posedge ref_clk) disable iff (!nrst)
		card_div == 5'h00 |=> !card_clk;
	endproperty
	a_card_zero: assert property (p_card_zero)
		else $error("card clock with zero divider");

	property p_idle_cpu;
		@(posedge ref_clk) disable iff (!nrst)
		idle |=> !cpu_clk;
	endproperty
	a_idle_cpu: assert property (p_idle_cpu)
		else $error("cpu clock runs in idle");

	property p_pd_osc;
		@(posedge ref_clk) disable iff (!nrst)
		power_down |=> !osc_clk && !osc_amp_enable;
	endproperty
	a_pd_osc: assert property (p_pd_osc)
		else $error("oscillator runs in power-down");

	property p_dnf_gate;
		@(posedge ref_clk) disable iff (!nrst)
		!s.en[CKC_EN_DNF] |=> !dataflow_flash_clk;
	endproperty
	a_dnf_gate: assert property (p_dnf_gate)
		else $error("shared clock without enable");

	property p_sys_switch;
		@(posedge ref_clk) disable iff (!nrst)
		s.sys_sel != $past(s.sys_sel)
			|-> !$past(sys_v) && !$past(sys_src[want_sys]);
	endproperty
	a_sys_switch: assert property (p_sys_switch)
		else $error("system source switched while high");

	property p_std_mode;
		@(posedge ref_clk) disable iff (!nrst)
		!s.cfg[CKC_CFG_X2] ##1 !s.cfg[CKC_CFG_X2]
			|-> per_clk == $past(s.sys_half);
	endproperty
	a_std_mode: assert property (p_std_mode)
		else $error("peripheral clock not halved in standard mode");
endmodule : ckc_clock_ctrl

// file: pkg/ckc_pkg.sv
// Constants of the chip clock generation controller.
// Assumes one 250 MHz reference clock and an 8-bit register port.
package ckc_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] CKC_OFS_CONFIG = 8'h8f;
	localparam logic [7:0] CKC_OFS_ENABLE = 8'hb9;
	localparam logic [7:0] CKC_OFS_SELECT = 8'hba;
	localparam logic [7:0] CKC_OFS_PLLDIV = 8'hbc;
	localparam logic [7:0] CKC_OFS_CARD = 8'hbd;
	localparam logic [7:0] CKC_RESET_VAL = 8'h00;
	// Writable bits; reserved and lock bits read zero or status
	localparam logic [7:0] CKC_CONFIG_WMASK = 8'h7f;
	localparam logic [7:0] CKC_ENABLE_WMASK = 8'hcb;
	// ==========================================================
	// Field positions
	localparam int CKC_CFG_X2 = 0;
	localparam int CKC_CFG_RANGE_LSB = 3;
	localparam int CKC_CFG_AMP_OFF = 5;
	localparam int CKC_EN_GEN = 7;
	localparam int CKC_EN_PLL = 6;
	localparam int CKC_EN_LOCK = 4;
	localparam int CKC_EN_CARD = 3;
	localparam int CKC_EN_SERIAL = 1;
	localparam int CKC_EN_DNF = 0;
	localparam int CKC_SEL_SYS_LSB = 0;
	localparam int CKC_SEL_SER = 2;
	localparam int CKC_SEL_FB_LSB = 3;
	localparam int CKC_SEL_DNF_LSB = 5;
	localparam int CKC_PLL_N_LSB = 0;
	localparam int CKC_PLL_R_LSB = 4;
	localparam int CKC_CARD_DIV_LSB = 0;
	localparam int CKC_CARD_SEL_LSB = 5;
	// ==========================================================
	// Generated frequencies, one phase accumulator each
	localparam int CKC_REF_KHZ = 250000;
	localparam int CKC_NCO_W = 24;
	localparam int CKC_NCO_N = 9;
	localparam int CKC_F12 = 0;
	localparam int CKC_F16 = 1;
	localparam int CKC_F20 = 2;
	localparam int CKC_F24 = 3;
	localparam int CKC_F30 = 4;
	localparam int CKC_F40 = 5;
	localparam int CKC_F48 = 6;
	localparam int CKC_F60 = 7;
	localparam int CKC_F120 = 8;
	localparam int CKC_NCO_KHZ [CKC_NCO_N] = '{12000, 16000, 20000,
		24000, 30000, 40000, 48000, 60000, 120000};
	localparam logic [1:0] CKC_FB_DIVIDED = 2'h3;
	localparam logic [2:0] CKC_CARD_OSC_HALF = 3'h7;

	function automatic logic [CKC_NCO_W-1:0] ckc_nco_inc(input int khz);
		return CKC_NCO_W'((64'(khz) << CKC_NCO_W) / 64'(CKC_REF_KHZ));
	endfunction : ckc_nco_inc
endpackage : ckc_pkg

// file: tb/ckc_clock_ctrl_tb_top.sv
// Self-checking bench of the clock generation controller.
// Assumes ckc_pkg is compiled first; drives every input of the block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
	n_fail++; $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module ckc_clock_ctrl_tb_top;
	import ckc_pkg::*;
	localparam int WIN = 1000;
	localparam int OSC_KHZ = 25000;
	logic ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
	logic osc_in = 1'b0, power_down = 1'b0, idle = 1'b0;
	logic pll_lock_raw = 1'b0, osc_amp_enable, pll_run, pll_locked_flag;
	logic [1:0] osc_range_sel;
	wire [7:0] mon;
	logic [7:0] offs [5] = '{CKC_OFS_CONFIG, CKC_OFS_ENABLE,
		CKC_OFS_SELECT, CKC_OFS_PLLDIV, CKC_OFS_CARD};
	int n_fail = 0, samples_checked = 0, cyc = 0, osc_cnt = 0;
	int sys_khz [3] = '{24000, 30000, 40000};
	int dnf_khz [8] = '{OSC_KHZ, 60000, 48000, 40000, 30000, 24000, 20000,
		16000};
	int card_khz [8] = '{OSC_KHZ, 60000, 48000, 30000, 24000, 20000, 16000,
		OSC_KHZ / 2};
	int fb_khz [3] = '{12000, 16000, 20000};
	always #2 ref_clk = ~ref_clk;
	// ==========================================================
	// Oscillator stand-in, 25 MHz from the reference
	always @(posedge ref_clk) begin
		osc_cnt <= (osc_cnt == 4) ? 0 : osc_cnt + 1;
		if (osc_cnt == 4) begin
			osc_in <= ~osc_in;
		end
	end
	ckc_clock_ctrl #(.LOCK_FILTER(4)) i_dut (
		.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .osc_in(osc_in), .power_down(power_down),
		.idle(idle), .pll_lock_raw(pll_lock_raw),
		.osc_range_sel(osc_range_sel), .osc_amp_enable(osc_amp_enable),
		.pll_run(pll_run), .pll_ref_clk(mon[6]),
		.pll_feedback_clk(mon[7]), .pll_locked_flag(pll_locked_flag),
		.osc_clk(mon[0]), .cpu_clk(mon[1]), .per_clk(mon[2]),
		.dataflow_flash_clk(mon[3]), .card_clk(mon[4]),
		.serial_baud_clk(mon[5]));
	// ==========================================================
	// Register port and measurement tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_cyc
	// Rising edges in a window; two edges of slack for accumulator phase
	task automatic meas(input string nm, input int idx, input int khz);
		int n;
		int e;
		logic p;
		n = 0;
		e = khz * WIN / CKC_REF_KHZ;
		wait_cyc(40);
		p = mon[idx];
		repeat (WIN) begin
			@(posedge ref_clk);
			#1;
			if (mon[idx] !== 1'b0 && mon[idx] !== 1'b1) n += 1000;
			if (mon[idx] && !p) n++;
			p = mon[idx];
		end
		if (n >= e - 2 && n <= e + 2) n = e;
		`CHK(nm, e, n)
	endtask : meas
	task automatic summarize();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_fail++;
			summarize();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		foreach (offs[i]) begin
			rd(offs[i], d);
			`CHK("reset value", CKC_RESET_VAL, d)
		end
		wr(8'h00, 8'hff);
		rd(8'h00, d);
		`CHK("unmapped read", 8'h00, d)
		wait_cyc(3);
		`CHK("amp on", 1'b1, osc_amp_enable)
		`CHK("lock idle", 1'b0, pll_locked_flag)
		meas("osc_clk", 0, OSC_KHZ);
		meas("cpu std", 1, OSC_KHZ / 2);
		meas("per std", 2, OSC_KHZ / 2);
		for (int r = 0; r < 4; r++) begin
			wr(CKC_OFS_CONFIG, 8'(r << 3));
			wait_cyc(3);
			`CHK("range", 2'(r), osc_range_sel)
		end
		wr(CKC_OFS_CONFIG, 8'hff);
		rd(CKC_OFS_CONFIG, d);
		`CHK("config rb", CKC_CONFIG_WMASK, d)
		wait_cyc(3);
		`CHK("amp off", 1'b0, osc_amp_enable)
		wr(CKC_OFS_CONFIG, 8'h01);
		meas("cpu x2", 1, OSC_KHZ);
		meas("per x2", 2, OSC_KHZ);
		wr(CKC_OFS_ENABLE, 8'hc0);
		wait_cyc(3);
		`CHK("pll run", 1'b1, pll_run)
		@(posedge ref_clk);
		pll_lock_raw <= 1'b1;
		wait_cyc(3);
		`CHK("lock early", 1'b0, pll_locked_flag)
		wait_cyc(10);
		`CHK("lock set", 1'b1, pll_locked_flag)
		wr(CKC_OFS_CARD, 8'h01);
		wr(CKC_OFS_ENABLE, 8'hef);
		rd(CKC_OFS_ENABLE, d);
		`CHK("enable rb", 8'hdb, d)
		for (int s = 1; s < 4; s++) begin
			wr(CKC_OFS_SELECT, 8'(s));
			meas("sys sel", 1, sys_khz[s-1]);
		end
		wr(CKC_OFS_SELECT, 8'h04);
		meas("serial fast", 5, 120000);
		wr(CKC_OFS_PLLDIV, 8'h11);
		for (int f = 0; f < 4; f++) begin
			wr(CKC_OFS_SELECT, 8'(f << 3));
			meas("fb sel", 7, (f < 3) ? fb_khz[f] : 6000);
		end
		meas("serial osc", 5, OSC_KHZ);
		meas("ref div", 6, OSC_KHZ / 2);
		for (int s = 0; s < 8; s++) begin
			wr(CKC_OFS_SELECT, 8'(s << 5));
			meas("dnf sel", 3, dnf_khz[s]);
			wr(CKC_OFS_CARD, 8'(s << 5) | 8'h01);
			meas("card sel", 4, card_khz[s]);
		end
		wr(CKC_OFS_CARD, 8'h23);
		meas("card div", 4, 20000);
		wr(CKC_OFS_CARD, 8'h20);
		meas("card off", 4, 0);
		wr(CKC_OFS_CARD, 8'h21);
		wr(CKC_OFS_SELECT, 8'h24);
		wr(CKC_OFS_ENABLE, 8'hc0);
		meas("dnf gated", 3, 0);
		meas("card gated", 4, 0);
		meas("serial gated", 5, 0);
		wr(CKC_OFS_ENABLE, 8'h4b);
		meas("gen off", 3, 0);
		wr(CKC_OFS_ENABLE, 8'h1b);
		wait_cyc(3);
		`CHK("lock drop", 1'b0, pll_locked_flag)
		`CHK("pll off", 1'b0, pll_run)
		rd(CKC_OFS_ENABLE, d);
		`CHK("lock ro", 8'h0b, d)
		@(posedge ref_clk);
		idle <= 1'b1;
		meas("cpu idle", 1, 0);
		meas("osc idle", 0, OSC_KHZ);
		@(posedge ref_clk);
		idle <= 1'b0;
		power_down <= 1'b1;
		meas("osc pd", 0, 0);
		`CHK("amp pd", 1'b0, osc_amp_enable)
		summarize();
	end
endmodule : ckc_clock_ctrl_tb_top
